// >>> design/pmrb_defines.vh
// Constants for the PHY management register bank: indices, fields, resets.
// Assumes inclusion by bare name from the design files.
`ifndef PMRB_DEFINES_VH
`define PMRB_DEFINES_VH
// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define PMRB_IDX_CTRL      5'h00
`define PMRB_IDX_STAT      5'h01
`define PMRB_IDX_ID_HI     5'h02
`define PMRB_IDX_ID_LO     5'h03
`define PMRB_IDX_ADV       5'h04
`define PMRB_IDX_LPA       5'h05
`define PMRB_IDX_EXP       5'h06
`define PMRB_IDX_MODE      5'h11
`define PMRB_IDX_SMODE     5'h12
`define PMRB_IDX_SIND      5'h1B
`define PMRB_IDX_ISRC      5'h1D
`define PMRB_IDX_IMSK      5'h1E
`define PMRB_IDX_SCTL      5'h1F
// ----------------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------------
`define PMRB_CTL_RST       15
`define PMRB_CTL_LOOP      14
`define PMRB_CTL_SPEED     13
`define PMRB_CTL_ANEN      12
`define PMRB_CTL_PDN       11
`define PMRB_CTL_ANRST     9
`define PMRB_CTL_DUPLEX    8
`define PMRB_CTL_COLTST    7
// ----------------------------------------------------------------------------
// Status field positions and constant ability bits
// ----------------------------------------------------------------------------
`define PMRB_STA_ANDONE    5
`define PMRB_STA_RFAULT    4
`define PMRB_STA_ANABLE    3
`define PMRB_STA_LINK      2
`define PMRB_STA_JABBER    1
`define PMRB_STA_EXTCAP    0
`define PMRB_STA_ABILITY   5'h0F
// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define PMRB_RST_ZERO      1'b0
`define PMRB_RST_WORD      16'h0000
`define PMRB_SRST_CYCLES   4'h4
`endif

// >>> design/pmrb_sync.v
// Two-flop synchroniser for one level input.
// Assumes the input is asynchronous to CLK.
`default_nettype none
module pmrb_sync (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Level
  input  wire d,
  output wire q
);
  reg s1_ff;
  reg s2_ff;
  always @(posedge clk) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
    end
  end
  assign q = s2_ff;
endmodule // pmrb_sync
`default_nettype wire

// >>> design/pmrb_latch_high.v
// Latch-high status flag: set by an event, cleared by a read, set wins.
// Assumes event and clear come from the CLK domain.
`default_nettype none
module pmrb_latch_high (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Control
  input  wire set_in,
  input  wire clr_in,
  output wire flag
);
  reg flag_ff;
  always @(posedge clk) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else if (set_in) begin
      flag_ff <= 1'b1;
    end else if (clr_in) begin
      flag_ff <= 1'b0;
    end
  end
  assign flag = flag_ff;
endmodule // pmrb_latch_high
`default_nettype wire

// >>> design/pmrb_regbank.v
// PHY management register bank: basic control, basic status, identifiers.
// Assumes the MAC management access logic drives index, strobes and data
// on CLK; PHY status pins are asynchronous and are synchronised here.
`default_nettype none
`include "pmrb_defines.vh"
module pmrb_regbank #(
  parameter [15:0] ID_HIGH  = 16'h1234, // Arbitrary value
  parameter [5:0]  ID_OUI   = 6'h2A,    // Arbitrary value
  parameter [5:0]  ID_MODEL = 6'h01,    // Arbitrary value
  parameter [3:0]  ID_REV   = 4'h1      // Arbitrary value
) (
  // Clock and reset
  input  wire        CLK,
  input  wire        SYS_RST,
  // Management access from the MAC
  input  wire [4:0]  MGMT_INDEX,
  input  wire        MGMT_WR,
  input  wire        MGMT_RD,
  input  wire [15:0] MGMT_WDATA,
  output wire [15:0] MGMT_RDATA,
  output wire        MGMT_RVALID,
  // Straps and PHY state pins
  input  wire        SPEED_SEL_PIN,
  input  wire        AN_DONE_PIN,
  input  wire        REMOTE_FAULT_PIN,
  input  wire        LINK_UP_PIN,
  input  wire        JABBER_PIN,
  // Control outputs to the PHY core
  output wire        SOFT_RESET,
  output wire        LOOPBACK,
  output wire        SPEED_100,
  output wire        FULL_DUPLEX,
  output wire        AN_ENABLE,
  output wire        AN_RESTART,
  output wire        POWER_DOWN,
  output wire        COL_TEST
);
  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  wire strap_s;
  wire andone_s;
  wire rfault_s;
  wire link_s;
  wire jab_s;
  pmrb_sync u_sync_strap (.clk(CLK), .rst(SYS_RST), .d(SPEED_SEL_PIN),    .q(strap_s));
  pmrb_sync u_sync_andn  (.clk(CLK), .rst(SYS_RST), .d(AN_DONE_PIN),      .q(andone_s));
  pmrb_sync u_sync_rflt  (.clk(CLK), .rst(SYS_RST), .d(REMOTE_FAULT_PIN), .q(rfault_s));
  pmrb_sync u_sync_link  (.clk(CLK), .rst(SYS_RST), .d(LINK_UP_PIN),      .q(link_s));
  pmrb_sync u_sync_jab   (.clk(CLK), .rst(SYS_RST), .d(JABBER_PIN),       .q(jab_s));

  // --------------------------------------------------------------------------
  // Strap capture after reset release
  // --------------------------------------------------------------------------
  reg [1:0] strap_cnt_ff;
  reg       strap_load_ff;
  always @(posedge CLK) begin
    if (SYS_RST) begin
      strap_cnt_ff  <= 2'h0;
      strap_load_ff <= 1'b0;
    end else begin
      // Load once the synchroniser has carried the strap level
      strap_load_ff <= (strap_cnt_ff == 2'h1);
      if (strap_cnt_ff != 2'h3) begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Access decode
  // --------------------------------------------------------------------------
  reg idx_ctrl;
  reg idx_stat;
  reg idx_known;
  always @* begin
    idx_ctrl  = 1'b0;
    idx_stat  = 1'b0;
    idx_known = 1'b1;
    if (MGMT_INDEX == `PMRB_IDX_CTRL) begin
      idx_ctrl = 1'b1;
    end else if (MGMT_INDEX == `PMRB_IDX_STAT) begin
      idx_stat = 1'b1;
    end else if (MGMT_INDEX == `PMRB_IDX_ID_HI || MGMT_INDEX == `PMRB_IDX_ID_LO ||
                 MGMT_INDEX == `PMRB_IDX_ADV   || MGMT_INDEX == `PMRB_IDX_LPA   ||
                 MGMT_INDEX == `PMRB_IDX_EXP   || MGMT_INDEX == `PMRB_IDX_MODE  ||
                 MGMT_INDEX == `PMRB_IDX_SMODE || MGMT_INDEX == `PMRB_IDX_SIND  ||
                 MGMT_INDEX == `PMRB_IDX_ISRC  || MGMT_INDEX == `PMRB_IDX_IMSK  ||
                 MGMT_INDEX == `PMRB_IDX_SCTL) begin
      idx_known = 1'b1;
    end else begin
      idx_known = 1'b0;
    end
  end

  wire ctrl_wr = MGMT_WR & idx_ctrl;
  wire stat_rd = MGMT_RD & idx_stat & ~MGMT_WR;

  // --------------------------------------------------------------------------
  // Soft reset sequencer
  // --------------------------------------------------------------------------
  reg [3:0] srst_cnt_ff;
  reg [3:0] nxt_srst_cnt;
  wire      srst_busy  = (srst_cnt_ff != 4'h0);
  wire      srst_end   = (srst_cnt_ff == 4'h1);
  // A new request is refused while one runs or the strap is loading
  wire      srst_start = ctrl_wr & MGMT_WDATA[`PMRB_CTL_RST] & ~srst_busy & ~strap_load_ff;
  always @* begin
    nxt_srst_cnt = srst_cnt_ff;
    if (srst_start) begin
      nxt_srst_cnt = `PMRB_SRST_CYCLES;
    end else if (srst_busy) begin
      nxt_srst_cnt = srst_cnt_ff - 4'h1;
    end
  end
  always @(posedge CLK) begin
    if (SYS_RST) begin
      srst_cnt_ff <= 4'h0;
    end else begin
      srst_cnt_ff <= nxt_srst_cnt;
    end
  end

  // --------------------------------------------------------------------------
  // Basic control register
  // --------------------------------------------------------------------------
  reg loop_ff;
  reg speed_ff;
  reg anen_ff;
  reg pdn_ff;
  reg anrst_ff;
  reg duplex_ff;
  reg coltst_ff;
  reg nxt_loop;
  reg nxt_speed;
  reg nxt_anen;
  reg nxt_pdn;
  reg nxt_anrst;
  reg nxt_duplex;
  reg nxt_coltst;
  always @* begin
    nxt_loop   = loop_ff;
    nxt_speed  = speed_ff;
    nxt_anen   = anen_ff;
    nxt_pdn    = pdn_ff;
    nxt_anrst  = 1'b0;
    nxt_duplex = duplex_ff;
    nxt_coltst = coltst_ff;
    if (strap_load_ff) begin
      nxt_speed = strap_s;
      nxt_anen  = strap_s;
    end else if (srst_end) begin
      // No field is immune to soft reset here, so all return to defaults
      nxt_loop   = `PMRB_RST_ZERO;
      nxt_speed  = strap_s;
      nxt_anen   = strap_s;
      nxt_pdn    = `PMRB_RST_ZERO;
      nxt_duplex = `PMRB_RST_ZERO;
      nxt_coltst = `PMRB_RST_ZERO;
    end else if (ctrl_wr && !srst_start && !srst_busy) begin
      // Bits 10 and 6..0 are not stored
      nxt_loop   = MGMT_WDATA[`PMRB_CTL_LOOP];
      nxt_speed  = MGMT_WDATA[`PMRB_CTL_SPEED];
      nxt_anen   = MGMT_WDATA[`PMRB_CTL_ANEN];
      nxt_pdn    = MGMT_WDATA[`PMRB_CTL_PDN];
      nxt_anrst  = MGMT_WDATA[`PMRB_CTL_ANRST];
      nxt_duplex = MGMT_WDATA[`PMRB_CTL_DUPLEX];
      nxt_coltst = MGMT_WDATA[`PMRB_CTL_COLTST];
    end
  end
  always @(posedge CLK) begin
    if (SYS_RST) begin
      loop_ff   <= `PMRB_RST_ZERO;
      speed_ff  <= `PMRB_RST_ZERO;
      anen_ff   <= `PMRB_RST_ZERO;
      pdn_ff    <= `PMRB_RST_ZERO;
      anrst_ff  <= `PMRB_RST_ZERO;
      duplex_ff <= `PMRB_RST_ZERO;
      coltst_ff <= `PMRB_RST_ZERO;
    end else begin
      loop_ff   <= nxt_loop;
      speed_ff  <= nxt_speed;
      anen_ff   <= nxt_anen;
      pdn_ff    <= nxt_pdn;
      anrst_ff  <= nxt_anrst;
      duplex_ff <= nxt_duplex;
      coltst_ff <= nxt_coltst;
    end
  end

  // --------------------------------------------------------------------------
  // Effective control outputs
  // --------------------------------------------------------------------------
  reg srst_o_ff;
  reg speed_o_ff;
  reg duplex_o_ff;
  always @(posedge CLK) begin
    if (SYS_RST) begin
      srst_o_ff   <= 1'b0;
      speed_o_ff  <= 1'b0;
      duplex_o_ff <= 1'b0;
    end else begin
      srst_o_ff <= (nxt_srst_cnt != 4'h0);
      // Under autoneg the manual selects do not drive the core
      speed_o_ff  <= nxt_anen ? 1'b0 : nxt_speed;
      duplex_o_ff <= nxt_anen ? 1'b0 : nxt_duplex;
    end
  end

  // --------------------------------------------------------------------------
  // Basic status register
  // --------------------------------------------------------------------------
  wire rfault_flag;
  pmrb_latch_high u_rfault (
    .clk    (CLK),
    .rst    (SYS_RST | srst_end),
    .set_in (rfault_s),
    .clr_in (stat_rd),
    .flag   (rfault_flag)
  );
  // Completion is only meaningful while powered up and negotiating
  wire an_done = andone_s & anen_ff & ~pdn_ff & ~srst_busy;
  wire [15:0] stat_word = {`PMRB_STA_ABILITY,
                           5'h00,
                           an_done,
                           rfault_flag,
                           1'b1,
                           link_s,
                           jab_s,
                           1'b1};
  wire [15:0] ctrl_word = {srst_busy, loop_ff, speed_ff, anen_ff, pdn_ff, 1'b0,
                           anrst_ff, duplex_ff, coltst_ff, 7'h00};

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  reg [15:0] rd_mux;
  always @* begin
    rd_mux = `PMRB_RST_WORD;
    if (idx_ctrl) begin
      rd_mux = ctrl_word;
    end else if (idx_stat) begin
      rd_mux = stat_word;
    end else if (MGMT_INDEX == `PMRB_IDX_ID_HI) begin
      rd_mux = ID_HIGH;
    end else if (MGMT_INDEX == `PMRB_IDX_ID_LO) begin
      rd_mux = {ID_OUI, ID_MODEL, ID_REV};
    end else if (!idx_known) begin
      rd_mux = `PMRB_RST_WORD;
    end
  end
  reg [15:0] rdata_ff;
  reg        rvalid_ff;
  always @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_ff  <= `PMRB_RST_WORD;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= MGMT_RD & ~MGMT_WR;
      if (MGMT_RD && !MGMT_WR) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign MGMT_RDATA  = rdata_ff;
  assign MGMT_RVALID = rvalid_ff;
  assign SOFT_RESET  = srst_o_ff;
  assign LOOPBACK    = loop_ff;
  assign SPEED_100   = speed_o_ff;
  assign FULL_DUPLEX = duplex_o_ff;
  assign AN_ENABLE   = anen_ff;
  assign AN_RESTART  = anrst_ff;
  assign POWER_DOWN  = pdn_ff;
  assign COL_TEST    = coltst_ff;
endmodule // pmrb_regbank
`default_nettype wire

// >>> test/pmrb_mac_model.sv
// MAC-side model of the indirect management access: index reads and writes.
// Assumes the register bank answers a read with a one-cycle valid pulse.
`default_nettype none
module pmrb_mac_model (
  // Clock
  input  wire logic        clk,
  // Requests
  output var  logic [4:0]  mgmt_index,
  output var  logic        mgmt_wr,
  output var  logic        mgmt_rd,
  output var  logic [15:0] mgmt_wdata,
  // Answers
  input  wire logic [15:0] mgmt_rdata,
  input  wire logic        mgmt_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  // Set by the bench to space requests apart
  bit slow = 1'b0;
  initial begin
    mgmt_index = 5'h00;
    mgmt_wr    = 1'b0;
    mgmt_rd    = 1'b0;
    mgmt_wdata = 16'h0000;
  end
  // Released lines show the inverse so stale values never match
  task automatic wr(input logic [4:0] idx, input logic [15:0] data);
    @(posedge clk);
    if (slow) repeat (3) @(posedge clk);
    mgmt_index <= idx;
    mgmt_wdata <= data;
    mgmt_wr    <= 1'b1;
    @(posedge clk);
    mgmt_wr    <= 1'b0;
    mgmt_index <= ~idx;
    mgmt_wdata <= ~data;
  endtask
  task automatic rd(input logic [4:0] idx, output logic [15:0] data, output bit ok);
    @(posedge clk);
    if (slow) repeat (3) @(posedge clk);
    mgmt_index <= idx;
    mgmt_rd    <= 1'b1;
    @(posedge clk);
    mgmt_rd    <= 1'b0;
    mgmt_index <= ~idx;
    ok = 1'b0;
    data = 16'h0000;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      ok = mgmt_rvalid;
      data = mgmt_rdata;
    end
  endtask
endmodule // pmrb_mac_model
`default_nettype wire

// >>> test/pmrb_regbank_asserts.sv
// Checker for the register bank, bound to its ports.
// Assumes CLK and the synchronous active-high SYS_RST of the bank.
`default_nettype none
module pmrb_regbank_asserts #(
  parameter [15:0] ID_HIGH  = 16'h1234,
  parameter [5:0]  ID_OUI   = 6'h2A,
  parameter [5:0]  ID_MODEL = 6'h01,
  parameter [3:0]  ID_REV   = 4'h1
) (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        SYS_RST,
  // Management access
  input wire logic [4:0]  MGMT_INDEX,
  input wire logic        MGMT_WR,
  input wire logic        MGMT_RD,
  input wire logic [15:0] MGMT_WDATA,
  input wire logic [15:0] MGMT_RDATA,
  input wire logic        MGMT_RVALID,
  // Control outputs
  input wire logic        SOFT_RESET,
  input wire logic        LOOPBACK,
  input wire logic        SPEED_100,
  input wire logic        FULL_DUPLEX,
  input wire logic        AN_ENABLE,
  input wire logic        AN_RESTART,
  input wire logic        POWER_DOWN,
  input wire logic        COL_TEST
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic rd_ok;
  assign rd_ok = MGMT_RD && !MGMT_WR;
  a_read_answered: assert property (rd_ok |=> MGMT_RVALID)
    else $error("read not answered");
  a_valid_cause: assert property (!$past(rd_ok) |-> !MGMT_RVALID)
    else $error("valid without read");
  a_unmapped_zero: assert property (rd_ok && MGMT_INDEX > 5'h03 |=> MGMT_RDATA == 16'h0000)
    else $error("unmapped index read not zero");
  a_id_high: assert property (rd_ok && MGMT_INDEX == 5'h02 |=> MGMT_RDATA == ID_HIGH)
    else $error("identifier high wrong");
  a_id_low: assert property (rd_ok && MGMT_INDEX == 5'h03 |=>
    MGMT_RDATA == {ID_OUI, ID_MODEL, ID_REV})
    else $error("identifier low wrong");
  a_status_fixed: assert property (rd_ok && MGMT_INDEX == 5'h01 |=>
    MGMT_RDATA[15:6] == 10'h1E0 && MGMT_RDATA[3] && MGMT_RDATA[0])
    else $error("status fixed bits wrong");
  a_srst_length: assert property ($rose(SOFT_RESET) |-> SOFT_RESET [*4] ##1 !SOFT_RESET)
    else $error("soft reset length wrong");
  a_srst_cause: assert property ($rose(SOFT_RESET) |->
    $past(MGMT_WR && MGMT_INDEX == 5'h00 && MGMT_WDATA[15]))
    else $error("soft reset without request");
  a_restart_pulse: assert property (AN_RESTART |=> !AN_RESTART)
    else $error("restart not a pulse");
  a_restart_cause: assert property (MGMT_WR && MGMT_INDEX == 5'h00 && MGMT_WDATA[9]
    && !MGMT_WDATA[15] && !SOFT_RESET |=> AN_RESTART)
    else $error("restart write not applied");
  a_manual_ignored: assert property (AN_ENABLE |-> !SPEED_100 && !FULL_DUPLEX)
    else $error("manual speed or duplex under autoneg");
  a_ctrl_write: assert property (MGMT_WR && MGMT_INDEX == 5'h00 && !MGMT_WDATA[15]
    && !SOFT_RESET |=> LOOPBACK == $past(MGMT_WDATA[14])
    && POWER_DOWN == $past(MGMT_WDATA[11]) && COL_TEST == $past(MGMT_WDATA[7]))
    else $error("control write not applied");
endmodule // pmrb_regbank_asserts
bind pmrb_regbank pmrb_regbank_asserts #(.ID_HIGH(ID_HIGH), .ID_OUI(ID_OUI),
  .ID_MODEL(ID_MODEL), .ID_REV(ID_REV)) u_pmrb_regbank_asserts (.CLK(CLK),
  .SYS_RST(SYS_RST), .MGMT_INDEX(MGMT_INDEX), .MGMT_WR(MGMT_WR), .MGMT_RD(MGMT_RD),
  .MGMT_WDATA(MGMT_WDATA), .MGMT_RDATA(MGMT_RDATA), .MGMT_RVALID(MGMT_RVALID),
  .SOFT_RESET(SOFT_RESET), .LOOPBACK(LOOPBACK), .SPEED_100(SPEED_100),
  .FULL_DUPLEX(FULL_DUPLEX), .AN_ENABLE(AN_ENABLE), .AN_RESTART(AN_RESTART),
  .POWER_DOWN(POWER_DOWN), .COL_TEST(COL_TEST));
`default_nettype wire

// >>> test/pmrb_regbank_tb_top.sv
// Self-checking bench for the register bank, driven through the MAC model.
// Assumes the default identifier parameters of the bank.
`default_nettype none
module pmrb_regbank_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        strap = 1'b1;
  logic        an_done = 1'b0;
  logic        rfault = 1'b0;
  logic        link = 1'b0;
  logic        jab = 1'b0;
  logic [4:0]  idx;
  logic        wr, rd, rvalid, srst, loop, spd, fdx, anen, anrst, pdn, col;
  logic [15:0] wdata, rdata;
  logic [4:0]  unmapped [10] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h11,
                                 5'h12, 5'h1B, 5'h1D, 5'h1E, 5'h1F};
  int failures = 0;
  int compares = 0;
  always #50 clk = ~clk;
  pmrb_mac_model u_pmrb_mac_model (.clk(clk), .mgmt_index(idx), .mgmt_wr(wr),
    .mgmt_rd(rd), .mgmt_wdata(wdata), .mgmt_rdata(rdata), .mgmt_rvalid(rvalid));
  pmrb_regbank u_pmrb_regbank (.CLK(clk), .SYS_RST(sys_rst), .MGMT_INDEX(idx),
    .MGMT_WR(wr), .MGMT_RD(rd), .MGMT_WDATA(wdata), .MGMT_RDATA(rdata),
    .MGMT_RVALID(rvalid), .SPEED_SEL_PIN(strap), .AN_DONE_PIN(an_done),
    .REMOTE_FAULT_PIN(rfault), .LINK_UP_PIN(link), .JABBER_PIN(jab),
    .SOFT_RESET(srst), .LOOPBACK(loop), .SPEED_100(spd), .FULL_DUPLEX(fdx),
    .AN_ENABLE(anen), .AN_RESTART(anrst), .POWER_DOWN(pdn), .COL_TEST(col));
  task automatic wrap_up();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [4:0] i, input logic [15:0] exp);
    logic [15:0] d;
    bit          ok;
    u_pmrb_mac_model.rd(i, d, ok);
    if (!ok) begin
      failures++;
      $display("ERROR t=%0t no read answer got=%h exp=%h", $time, d, exp);
      wrap_up();
    end
    chk(d, exp);
  endtask
  task automatic w(input logic [4:0] i, input logic [15:0] d);
    u_pmrb_mac_model.wr(i, d);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    rc(5'h00, 16'h3000);
    rc(5'h01, 16'h7809);
    rc(5'h02, 16'h1234);
    rc(5'h03, 16'hA811);
    u_pmrb_mac_model.slow = 1'b1;
    foreach (unmapped[k]) begin
      w(unmapped[k], 16'h8000);
      rc(unmapped[k], 16'h0000);
    end
    u_pmrb_mac_model.slow = 1'b0;
    rc(5'h00, 16'h3000);
    w(5'h00, 16'h6DFF);
    rc(5'h00, 16'h6980);
    chk({10'h000, loop, spd, fdx, anen, pdn, col}, 16'h003B);
    w(5'h00, 16'h3100);
    rc(5'h00, 16'h3100);
    chk({10'h000, loop, spd, fdx, anen, pdn, col}, 16'h0004);
    w(5'h00, 16'h1200);
    rc(5'h00, 16'h1000);
    an_done <= 1'b1;
    link <= 1'b1;
    jab <= 1'b1;
    repeat (4) @(posedge clk);
    rc(5'h01, 16'h782F);
    rfault <= 1'b1;
    repeat (4) @(posedge clk);
    rfault <= 1'b0;
    repeat (4) @(posedge clk);
    rc(5'h01, 16'h783F);
    rc(5'h01, 16'h782F);
    w(5'h00, 16'h1800);
    rc(5'h01, 16'h780F);
    strap <= 1'b0;
    repeat (4) @(posedge clk);
    w(5'h00, 16'hC000);
    w(5'h00, 16'h4000);
    chk({15'h0000, srst}, 16'h0001);
    repeat (8) @(posedge clk);
    rc(5'h00, 16'h0000);
    rc(5'h01, 16'h780F);
    wrap_up();
  end
endmodule // pmrb_regbank_tb_top
`default_nettype wire
